/* framebuffer_pixel_packer.sv */
/*
  frame buffer pixel packer: maps a pixel coordinate to a byte address, bit
  position and lane mask, and converts colours to and from the pixel format.
  assumes: format, packing and scan order are build-time parameters; the
  drawing engine presents one request per cycle and the memory side uses the
  registered answer one cycle later.
*/
// Functional notes
// - sub-byte formats pack several pixels per byte; packing order only affects them
// - line packing: byte holds adjacent row pixels; rows start on fresh byte
// - column packing: byte holds adjacent column pixels; columns start on fresh byte
// - first pixel in least significant bits, later pixels toward msb
// - wide formats stored row by row from top; 16 bit pixel x at 2x
// - multi-byte pixels stored lsb first, gapless; 24 bit takes three bytes
// - sub-byte formats support row scan or column scan frame order
// - row scan, line packing: successive bytes are successive row groups
// - row scan, column packing: successive bytes step one column right
// - column scan, line packing: successive bytes step one row down
// - argb8888 holds four 8 bit channels; conversion is identity
// - rgb888 holds 8 bit red, green, blue, no alpha
// - rgb565 holds 5 red, 6 green, 5 blue, no alpha
// - 1555 encode: bit 15 only when fully opaque, top five bits per colour
// - 1555 decode: alpha bit to full byte, colours shifted left three
// - 4444 keeps upper nibbles; decode duplicates each nibble
// - plain bit count formats use integrator conversion hooks
`timescale 1ns/100ps
module framebuffer_pixel_packer
  import pixel_packer_pkg::*;
#(
  parameter pixel_format_e        PIXEL_FORMAT        = FMT_ARGB8888, // pixel format
  parameter pixel_packing_order_e PIXEL_PACKING_ORDER = PACK_LINE,    // narrow format packing
  parameter frame_scan_order_e    FRAME_SCAN_ORDER    = SCAN_ROW,     // narrow format scan
  parameter int unsigned          FB_WIDTH            = FB_WIDTH_DEF, // pixels per row
  parameter int unsigned          FB_HEIGHT           = FB_HEIGHT_DEF // pixels per column
) (
  input  wire logic        mclk_i,       // clock, 40 MHz
  input  wire logic        nrst_i,       // synchronous reset, active low
  input  wire logic        req_valid_i,  // request strobe
  input  wire pixel_req_s  req_i,        // coordinate, colour and read-back pixel
  input  wire logic [31:0] hook_pixel_i, // integrator encoder result
  input  wire logic [31:0] hook_argb_i,  // integrator decoder result
  output logic             rsp_valid_o,  // answer strobe, one cycle
  output pixel_rsp_s       rsp_o         // address, lanes, pixel and colour
);

  // ==========================================================================
  // static geometry, fixed at build time so no mid-frame reconfiguration hazard
  localparam logic [5:0] BPP = bits_per_pixel(PIXEL_FORMAT);
  localparam logic [3:0] PIX_PER_BYTE = (BPP < 6'h08) ? 4'(8 / BPP) : 4'h1;
  localparam logic [2:0] PIX_BYTES = (BPP >= 6'h08) ? 3'(BPP / 8) : 3'h1;
  localparam logic [ADDR_W-1:0] WIDTH_A = ADDR_W'(FB_WIDTH);
  localparam logic [ADDR_W-1:0] HEIGHT_A = ADDR_W'(FB_HEIGHT);
  // padded byte counts per row and per column
  // divisor is pixels per byte, never zero, so wide formats elaborate cleanly too
  localparam logic [ADDR_W-1:0] ROW_BYTES = ADDR_W'((FB_WIDTH + PIX_PER_BYTE - 1) / PIX_PER_BYTE);
  localparam logic [ADDR_W-1:0] COL_BYTES = ADDR_W'((FB_HEIGHT + PIX_PER_BYTE - 1) / PIX_PER_BYTE);
  localparam logic [2:0] LOG_PPB = (PIX_PER_BYTE == 4'h8) ? 3'h3 :
                                   (PIX_PER_BYTE == 4'h4) ? 3'h2 :
                                   (PIX_PER_BYTE == 4'h2) ? 3'h1 : 3'h0;

  // ==========================================================================
  // colour conversion
  logic [31:0] enc_pixel;
  logic [31:0] dec_argb;

  pixel_color_converter u_conv (
    .fmt_i        (PIXEL_FORMAT),
    .argb_i       (req_i.argb),
    .raw_i        (req_i.raw),
    .hook_pixel_i (hook_pixel_i),
    .hook_argb_i  (hook_argb_i),
    .pixel_o      (enc_pixel),
    .argb_o       (dec_argb)
  );

  // ==========================================================================
  // address and bit position
  logic [ADDR_W-1:0]  x_a;
  logic [ADDR_W-1:0]  y_a;
  logic [ADDR_W-1:0]  x_grp;
  logic [ADDR_W-1:0]  y_grp;
  logic [2:0]         x_sub;
  logic [2:0]         y_sub;
  logic [ADDR_W-1:0]  addr_calc;
  logic [2:0]         slot;
  logic [SHIFT_W-1:0] shift_calc;
  logic [31:0]        lane_mask;

  // group index is coordinate divided by pixels per byte, slot is the remainder
  always_comb begin
    x_a   = ADDR_W'(req_i.x);
    y_a   = ADDR_W'(req_i.y);
    x_grp = x_a >> LOG_PPB;
    y_grp = y_a >> LOG_PPB;
    x_sub = 3'(req_i.x[2:0] & 3'(PIX_PER_BYTE - 4'h1));
    y_sub = 3'(req_i.y[2:0] & 3'(PIX_PER_BYTE - 4'h1));
    addr_calc = ADDR_RST;
    slot      = 3'h0;
    if (BPP >= 6'h08) begin
      // row by row, lsb first, no gaps between pixels
      addr_calc = ADDR_W'((y_a * WIDTH_A + x_a) * ADDR_W'(PIX_BYTES));
    end else if (FRAME_SCAN_ORDER == SCAN_ROW) begin
      if (PIXEL_PACKING_ORDER == PACK_LINE) begin
        addr_calc = ADDR_W'(y_a * ROW_BYTES + x_grp);
        slot      = x_sub;
      end else begin
        addr_calc = ADDR_W'(y_grp * WIDTH_A + x_a);
        slot      = y_sub;
      end
    end else begin
      if (PIXEL_PACKING_ORDER == PACK_LINE) begin
        addr_calc = ADDR_W'(x_grp * HEIGHT_A + y_a);
        slot      = x_sub;
      end else begin
        addr_calc = ADDR_W'(x_a * COL_BYTES + y_grp);
        slot      = y_sub;
      end
    end
    // first pixel of a byte sits at the lsb end
    shift_calc = SHIFT_W'(6'(slot) * BPP);
  end

  // ==========================================================================
  // lane mask, one bit per pixel bit, built per bit position
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_mask
      always_comb begin
        if (BPP >= 6'h08) begin
          lane_mask[gi] = (6'(gi) < BPP);
        end else begin
          lane_mask[gi] = (gi < 8) && (6'(gi) >= 6'(shift_calc)) && (6'(gi) < 6'(shift_calc) + BPP);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // answer stage next values
  logic       rsp_valid_reg;
  logic       rsp_valid_next;
  pixel_rsp_s rsp_reg;
  pixel_rsp_s rsp_next;

  // answer holds its value between requests so memory side may sample late
  always_comb begin
    rsp_valid_next = req_valid_i;
    rsp_next       = rsp_reg;
    if (req_valid_i) begin
      rsp_next.byte_addr  = addr_calc;
      rsp_next.bit_shift  = shift_calc;
      rsp_next.byte_count = PIX_BYTES;
      // narrow pixels are moved to their slot so a read-modify-write just masks
      rsp_next.pixel      = (BPP < 6'h08) ? (enc_pixel << shift_calc) & lane_mask : enc_pixel & lane_mask;
      rsp_next.pixel_mask = lane_mask;
      rsp_next.argb       = dec_argb;
    end
  end

  // answer registers
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rsp_valid_reg       <= 1'b0;
      rsp_reg.byte_addr   <= ADDR_RST;
      rsp_reg.bit_shift   <= '0;
      rsp_reg.byte_count  <= '0;
      rsp_reg.pixel       <= PIXEL_RST;
      rsp_reg.pixel_mask  <= PIXEL_RST;
      rsp_reg.argb        <= PIXEL_RST;
    end else begin
      rsp_valid_reg <= rsp_valid_next;
      rsp_reg       <= rsp_next;
    end
  end

  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_o       = rsp_reg;

endmodule : framebuffer_pixel_packer

/* pixel_packer_pkg.sv */
/*
  shared constants, format enumeration and request/response structs for the
  frame buffer pixel packer.
  assumes: frame buffer is byte addressed and starts at byte address zero.
*/
package pixel_packer_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned COORD_W = 16;
  localparam int unsigned ADDR_W  = 32;
  localparam int unsigned SHIFT_W = 3;

  // ==========================================================================
  // default geometry
  localparam int unsigned FB_WIDTH_DEF  = 320;
  localparam int unsigned FB_HEIGHT_DEF = 240;

  // ==========================================================================
  // luminance weights, sum is 256 so the gray level needs no rounding step
  localparam logic [7:0] LUMA_R = 8'h4d;
  localparam logic [7:0] LUMA_G = 8'h96;
  localparam logic [7:0] LUMA_B = 8'h1d;

  // ==========================================================================
  // gray scale divisors and opaque alpha
  localparam logic [7:0] GRAY4_DIV = 8'h11;
  localparam logic [7:0] GRAY2_DIV = 8'h55;
  localparam logic [7:0] GRAY1_DIV = 8'hff;
  localparam logic [7:0] ALPHA_OPAQUE = 8'hff;

  // ==========================================================================
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST  = 32'h0000_0000;
  localparam logic [31:0]       PIXEL_RST = 32'h0000_0000;

  // ==========================================================================
  // pixel formats: standard ones first, integrator hook formats after
  typedef enum logic [3:0] {
    FMT_ARGB8888 = 4'h0,
    FMT_RGB888   = 4'h1,
    FMT_RGB565   = 4'h2,
    FMT_ARGB1555 = 4'h3,
    FMT_ARGB4444 = 4'h4,
    gray_nibble_format  = 4'h5,
    gray_two_bit_format = 4'h6,
    gray_one_bit_format = 4'h7,
    FMT_HOOK1    = 4'h8,
    FMT_HOOK2    = 4'h9,
    FMT_HOOK4    = 4'ha,
    FMT_HOOK8    = 4'hb,
    FMT_HOOK16   = 4'hc,
    FMT_HOOK24   = 4'hd,
    FMT_HOOK32   = 4'he
  } pixel_format_e;

  typedef enum logic {
    PACK_LINE   = 1'b0,
    PACK_COLUMN = 1'b1
  } pixel_packing_order_e;

  typedef enum logic {
    SCAN_ROW    = 1'b0,
    SCAN_COLUMN = 1'b1
  } frame_scan_order_e;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [COORD_W-1:0] x;
    logic [COORD_W-1:0] y;
    logic [31:0]        argb;   // colour to encode
    logic [31:0]        raw;    // pixel read back from memory, to decode
  } pixel_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0]  byte_addr;
    logic [SHIFT_W-1:0] bit_shift;
    logic [2:0]         byte_count;
    logic [31:0]        pixel;
    logic [31:0]        pixel_mask;
    logic [31:0]        argb;
  } pixel_rsp_s;

  // ==========================================================================
  // bits per pixel of a format
  function automatic logic [5:0] bits_per_pixel(input pixel_format_e f);
    case (f)
      FMT_ARGB8888, FMT_HOOK32: bits_per_pixel = 6'h20;
      FMT_RGB888, FMT_HOOK24: bits_per_pixel = 6'h18;
      FMT_RGB565, FMT_ARGB1555, FMT_ARGB4444, FMT_HOOK16: bits_per_pixel = 6'h10;
      FMT_HOOK8: bits_per_pixel = 6'h08;
      gray_nibble_format, FMT_HOOK4: bits_per_pixel = 6'h04;
      gray_two_bit_format, FMT_HOOK2: bits_per_pixel = 6'h02;
      default: bits_per_pixel = 6'h01;
    endcase
  endfunction : bits_per_pixel

endpackage : pixel_packer_pkg

/* pixel_color_converter.sv */
/*
  combinational colour converter between 32-bit argb and the frame buffer
  pixel formats.
  assumes: hook formats are converted by integrator logic that drives the
  hook inputs from the same request inputs.
*/
`timescale 1ns/100ps
module pixel_color_converter
  import pixel_packer_pkg::*;
(
  input  wire pixel_format_e fmt_i,        // selected pixel format
  input  wire logic [31:0]   argb_i,       // colour to encode
  input  wire logic [31:0]   raw_i,        // pixel to decode
  input  wire logic [31:0]   hook_pixel_i, // integrator encoded pixel
  input  wire logic [31:0]   hook_argb_i,  // integrator decoded colour
  output logic      [31:0]   pixel_o,      // encoded pixel, low aligned
  output logic      [31:0]   argb_o        // decoded colour
);

  // ==========================================================================
  // gray level
  logic [15:0] luma_sum;
  logic [7:0]  luminance_of;
  logic [7:0]  g4;
  logic [7:0]  g2;

  // fixed weighting, shift by 8 because weights sum to 256
  always_comb begin
    luma_sum = 16'(LUMA_R * argb_i[23:16]) + 16'(LUMA_G * argb_i[15:8]) + 16'(LUMA_B * argb_i[7:0]);
    luminance_of = luma_sum[15:8];
    g4 = luminance_of / GRAY4_DIV;
    g2 = luminance_of / GRAY2_DIV;
  end

  // ==========================================================================
  // encode and decode per format
  always_comb begin
    pixel_o = 32'h0000_0000;
    argb_o  = 32'h0000_0000;
    case (fmt_i)
      FMT_ARGB8888: begin
        pixel_o = argb_i;
        argb_o  = raw_i;
      end
      FMT_RGB888: begin
        pixel_o = {8'h00, argb_i[23:0]};
        argb_o  = {ALPHA_OPAQUE, raw_i[23:0]};
      end
      FMT_RGB565: begin
        pixel_o = {16'h0000, argb_i[23:19], argb_i[15:10], argb_i[7:3]};
        argb_o  = {ALPHA_OPAQUE, raw_i[15:11], 3'h0, raw_i[10:5], 2'h0, raw_i[4:0], 3'h0};
      end
      FMT_ARGB1555: begin
        pixel_o = {16'h0000, (argb_i[31:24] == ALPHA_OPAQUE), argb_i[23:19], argb_i[15:11], argb_i[7:3]};
        argb_o  = {{8{raw_i[15]}}, raw_i[14:10], 3'h0, raw_i[9:5], 3'h0, raw_i[4:0], 3'h0};
      end
      FMT_ARGB4444: begin
        pixel_o = {16'h0000, argb_i[31:28], argb_i[23:20], argb_i[15:12], argb_i[7:4]};
        argb_o  = {{2{raw_i[15:12]}}, {2{raw_i[11:8]}}, {2{raw_i[7:4]}}, {2{raw_i[3:0]}}};
      end
      gray_nibble_format: begin
        pixel_o = {28'h0000000, g4[3:0]};
        argb_o  = {ALPHA_OPAQUE, {6{raw_i[3:0]}}};
      end
      gray_two_bit_format: begin
        pixel_o = {30'h00000000, g2[1:0]};
        argb_o  = {ALPHA_OPAQUE, {12{raw_i[1:0]}}};
      end
      gray_one_bit_format: begin
        pixel_o = {31'h00000000, (luminance_of == GRAY1_DIV)};
        argb_o  = {ALPHA_OPAQUE, {24{raw_i[0]}}};
      end
      default: begin
        pixel_o = hook_pixel_i;
        argb_o  = hook_argb_i;
      end
    endcase
  end

endmodule : pixel_color_converter

/* pixel_packer_chk.sv */
/*
  port checker for the frame buffer pixel packer: latency, hold, lane and gray
  nibble decode relations; address for narrow formats with row scan, line packing.
  assumes: bound to every packer instance; only ports are visible.
*/
`timescale 1ns/100ps
module pixel_packer_chk
  import pixel_packer_pkg::*;
#(
  parameter pixel_format_e        PIXEL_FORMAT        = FMT_ARGB8888,
  parameter pixel_packing_order_e PIXEL_PACKING_ORDER = PACK_LINE,
  parameter frame_scan_order_e    FRAME_SCAN_ORDER    = SCAN_ROW,
  parameter int unsigned          FB_WIDTH            = FB_WIDTH_DEF,
  parameter int unsigned          FB_HEIGHT           = FB_HEIGHT_DEF
) (
  input wire logic        mclk_i,      // clock
  input wire logic        nrst_i,      // sync reset, active low
  input wire logic        req_valid_i, // request strobe
  input wire pixel_req_s  req_i,       // request
  input wire logic [31:0] hook_pixel_i, // unused here
  input wire logic [31:0] hook_argb_i, // unused here
  input wire logic        rsp_valid_o, // answer strobe
  input wire pixel_rsp_s  rsp_o        // answer
);
  // ==========================================================================
  // helper state: last taken request
  localparam int unsigned BPP = bits_per_pixel(PIXEL_FORMAT);
  localparam int unsigned PPB = (BPP < 8) ? 8 / BPP : 1;
  localparam int unsigned ROW_BYTES = (FB_WIDTH + PPB - 1) / PPB; // padded row
  localparam bit NARROW_RL = (BPP < 8) && (PIXEL_PACKING_ORDER == PACK_LINE) && (FRAME_SCAN_ORDER == SCAN_ROW);
  logic [COORD_W-1:0] x_reg;
  logic [COORD_W-1:0] y_reg;
  logic [31:0]        raw_reg;
  // capture on every taken request so answers can be judged against their cause
  always_ff @(posedge mclk_i) begin
    if (req_valid_i) begin
      x_reg   <= req_i.x;
      y_reg   <= req_i.y;
      raw_reg <= req_i.raw;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  AST_RSP_ONE_CYCLE: assert property (req_valid_i |=> rsp_valid_o) else $error("answer missing after request");
  AST_NO_SPURIOUS: assert property (!req_valid_i |=> !rsp_valid_o) else $error("answer without request");
  AST_HOLD: assert property (!req_valid_i |=> $stable(rsp_o)) else $error("answer changed while idle");
  AST_RESET_CLEAR: assert property (disable iff (1'b0) !nrst_i |=> (!rsp_valid_o && rsp_o == '0))
    else $error("answer not cleared by reset");
  AST_ROW_ADDR: assert property (rsp_valid_o && NARROW_RL |-> rsp_o.byte_addr == 32'(y_reg * ROW_BYTES + x_reg / PPB))
    else $error("narrow byte address wrong");
  AST_LSB_FIRST: assert property (rsp_valid_o && NARROW_RL |-> rsp_o.bit_shift == 3'((x_reg % PPB) * BPP))
    else $error("bit position wrong");
  AST_LANE_MASK: assert property (rsp_valid_o && BPP < 8 |-> rsp_o.pixel_mask == ((32'h1 << BPP) - 1) << rsp_o.bit_shift)
    else $error("lane mask wrong");
  AST_PIXEL_IN_LANE: assert property (rsp_valid_o |-> (rsp_o.pixel & ~rsp_o.pixel_mask) == 32'h0)
    else $error("pixel outside its lanes");
  AST_GRAY4_DECODE: assert property (rsp_valid_o && PIXEL_FORMAT == gray_nibble_format
    |-> rsp_o.argb == (32'hff000000 | (32'(raw_reg[3:0]) * 32'h00111111)))
    else $error("gray decode wrong");
endmodule : pixel_packer_chk

bind framebuffer_pixel_packer pixel_packer_chk #(.PIXEL_FORMAT(PIXEL_FORMAT), .PIXEL_PACKING_ORDER(PIXEL_PACKING_ORDER),
  .FRAME_SCAN_ORDER(FRAME_SCAN_ORDER), .FB_WIDTH(FB_WIDTH), .FB_HEIGHT(FB_HEIGHT)) u_chk (.mclk_i(mclk_i),
  .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_i(req_i), .hook_pixel_i(hook_pixel_i),
  .hook_argb_i(hook_argb_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));

/* fb_memory_model.sv */
/*
  frame buffer memory model: applies each answer as a masked byte write.
  assumes: small frames, 64 bytes of store; reads are combinational.
*/
`timescale 1ns/100ps
module fb_memory_model
  import pixel_packer_pkg::*;
(
  input  wire logic       mclk_i,      // clock
  input  wire logic       rsp_valid_i, // answer strobe
  input  wire pixel_rsp_s rsp_i,       // address, lanes, pixel
  input  wire logic [5:0] rd_addr_i,   // read address
  output logic      [7:0] rd_byte_o    // read byte
);
  // ==========================================================================
  // store, cleared so unwritten lanes read a known level
  logic [7:0] mem [64];
  initial foreach (mem[i]) mem[i] = 8'h00;
  // lsb byte first at byte_addr; only masked lanes change, neighbours survive
  always @(posedge mclk_i) begin
    if (rsp_valid_i) begin
      for (int k = 0; k < 4; k++) begin
        if (k < int'(rsp_i.byte_count) || k == 0) begin
          mem[6'(rsp_i.byte_addr + k)] <= (mem[6'(rsp_i.byte_addr + k)] & ~rsp_i.pixel_mask[8*k+:8])
                                          | (rsp_i.pixel[8*k+:8] & rsp_i.pixel_mask[8*k+:8]);
        end
      end
    end
  end
  assign rd_byte_o = mem[rd_addr_i];
endmodule : fb_memory_model

/* tb_top.sv */
/*
  testbench: gray nibble format, line packing, row scan, 5x4 frame so rows pad;
  beside it a 1555 build and a 2 bit column/column build on the same stimulus.
  assumes: one answer per request one cycle later; inputs move at falling edge.
*/
`timescale 1ns/100ps
module tb_top
  import pixel_packer_pkg::*;
;
  // ==========================================================================
  // signals
  logic        mclk_i;
  logic        nrst_i;
  logic        req_valid_i;
  pixel_req_s  req_i;
  logic        rsp_valid_o;
  pixel_rsp_s  rsp_o;
  logic        rsp_valid_w;
  pixel_rsp_s  rsp_w;
  logic        rsp_valid_c;
  pixel_rsp_s  rsp_c;
  logic [5:0]  rd_addr;
  logic [7:0]  rd_byte;
  int          n_errors;
  int          num_checks;

  framebuffer_pixel_packer #(.PIXEL_FORMAT(gray_nibble_format), .PIXEL_PACKING_ORDER(PACK_LINE),
    .FRAME_SCAN_ORDER(SCAN_ROW), .FB_WIDTH(5), .FB_HEIGHT(4)) dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .hook_pixel_i(32'h0), .hook_argb_i(32'h0),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));
  fb_memory_model mem (.mclk_i(mclk_i), .rsp_valid_i(rsp_valid_o), .rsp_i(rsp_o), .rd_addr_i(rd_addr),
    .rd_byte_o(rd_byte));
  // wide format and column/column builds share the request wires, so one stimulus reaches all three
  framebuffer_pixel_packer #(.PIXEL_FORMAT(FMT_ARGB1555), .FB_WIDTH(5), .FB_HEIGHT(4)) dut_wide (.mclk_i(mclk_i),
    .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_i(req_i), .hook_pixel_i(32'h0), .hook_argb_i(32'h0),
    .rsp_valid_o(rsp_valid_w), .rsp_o(rsp_w));
  framebuffer_pixel_packer #(.PIXEL_FORMAT(gray_two_bit_format), .PIXEL_PACKING_ORDER(PACK_COLUMN),
    .FRAME_SCAN_ORDER(SCAN_COLUMN), .FB_WIDTH(5), .FB_HEIGHT(6)) dut_col (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .hook_pixel_i(32'h0), .hook_argb_i(32'h0),
    .rsp_valid_o(rsp_valid_c), .rsp_o(rsp_c));

  // ==========================================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic send(input int x, input int y, input logic [31:0] argb, input logic [31:0] raw);
    req_valid_i = 1'b1;
    req_i = '{x: COORD_W'(x), y: COORD_W'(y), argb: argb, raw: raw};
  endtask : send
  // gray level from the fixed weighting, then scaled to a nibble
  function automatic logic [31:0] gray4(input logic [31:0] c);
    gray4 = ((LUMA_R * c[23:16] + LUMA_G * c[15:8] + LUMA_B * c[7:0]) >> 8) / GRAY4_DIV;
  endfunction : gray4

  // ==========================================================================
  // scenarios
  task automatic t_coords();
    int cx[5] = '{0, 1, 4, 0, 3};
    int cy[5] = '{0, 0, 0, 1, 2};
    int ea[5] = '{0, 0, 2, 3, 7};
    int es[5] = '{0, 4, 0, 0, 4};
    for (int i = 0; i <= 5; i++) begin
      @(negedge mclk_i);
      if (i > 0) begin
        chk("rsp_valid", 32'h1, 32'(rsp_valid_o));
        chk("byte_addr", 32'(ea[i-1]), rsp_o.byte_addr);
        chk("bit_shift", 32'(es[i-1]), 32'(rsp_o.bit_shift));
        chk("pixel_mask", 32'hf << es[i-1], rsp_o.pixel_mask);
        chk("pixel", 32'hf << es[i-1], rsp_o.pixel);
      end
      if (i < 5) send(cx[i], cy[i], 32'hffffffff, 32'h0);
      else req_valid_i = 1'b0;
    end
  endtask : t_coords
  task automatic t_colours();
    logic [31:0] col[4] = '{32'hff808080, 32'hffff0000, 32'hff0000ff, 32'h00000000};
    for (int i = 0; i <= 4; i++) begin
      @(negedge mclk_i);
      if (i > 0) begin
        chk("gray_pixel", gray4(col[i-1]), rsp_o.pixel);
        chk("gray_argb", 32'hff000000 | (32'(5 * (i - 1)) * 32'h00111111), rsp_o.argb);
      end
      if (i < 4) send(2, 3, col[i], 32'(5 * i));
      else req_valid_i = 1'b0;
    end
  endtask : t_colours
  task automatic t_shared_byte();
    @(negedge mclk_i);
    send(0, 2, 32'hffff0000, 32'h0);
    @(negedge mclk_i);
    send(1, 2, 32'hff0000ff, 32'h0);
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    rd_addr = 6'h06;
    @(negedge mclk_i);
    chk("shared_byte", (gray4(32'hff0000ff) << 4) | gray4(32'hffff0000), 32'(rd_byte));
  endtask : t_shared_byte
  // 1555 pixels on the wide build, 2 bit pixels on the column/column build; 6 rows pad to 2 bytes
  task automatic t_wide();
    @(negedge mclk_i);
    send(3, 1, 32'hfff80f18, 32'h00008421);
    @(negedge mclk_i);
    send(0, 0, 32'h7fffffff, 32'h00007fff);
    chk("w_valid", 32'h1, 32'(rsp_valid_w));
    chk("w_addr", 32'h10, rsp_w.byte_addr);
    chk("w_count", 32'h2, 32'(rsp_w.byte_count));
    chk("w_mask", 32'hffff, rsp_w.pixel_mask);
    chk("w_pixel", 32'hfc23, rsp_w.pixel);
    chk("w_argb", 32'hff080808, rsp_w.argb);
    chk("c_valid", 32'h1, 32'(rsp_valid_c));
    chk("c_addr", 32'h6, rsp_c.byte_addr);
    chk("c_shift", 32'h2, 32'(rsp_c.bit_shift));
    chk("c_pixel", 32'h4, rsp_c.pixel);
    chk("c_argb", 32'hff555555, rsp_c.argb);
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    chk("w_addr0", 32'h0, rsp_w.byte_addr);
    chk("w_pixel0", 32'h7fff, rsp_w.pixel);
    chk("w_argb0", 32'h00f8f8f8, rsp_w.argb);
    chk("c_mask0", 32'h3, rsp_c.pixel_mask);
    chk("c_pixel0", 32'h3, rsp_c.pixel);
    chk("c_argb0", 32'hffffffff, rsp_c.argb);
  endtask : t_wide
  task automatic t_reset_mid();
    @(negedge mclk_i);
    send(4, 3, 32'hffffffff, 32'h0000000f);
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    nrst_i = 1'b0;
    @(negedge mclk_i);
    chk("rst_valid", 32'h0, 32'(rsp_valid_o));
    chk("rst_addr", 32'h0, rsp_o.byte_addr);
    chk("rst_argb", 32'h0, rsp_o.argb);
    nrst_i = 1'b1;
  endtask : t_reset_mid

  // ==========================================================================
  // verdict, the single place the run ends
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // 40 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // watchdog: tests take under 100 cycles, so 2000 means a hang
  initial begin
    #(25 * 2000);
    n_errors++;
    give_verdict();
  end
  // main sequence
  initial begin
    n_errors = 0;
    num_checks = 0;
    nrst_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    rd_addr = 6'h00;
    repeat (12) @(negedge mclk_i);
    chk("boot_valid", 32'h0, 32'(rsp_valid_o));
    nrst_i = 1'b1;
    t_coords();
    t_colours();
    t_shared_byte();
    t_wide();
    t_reset_mid();
    t_coords();
    give_verdict();
  end
endmodule : tb_top
